// >>> rtl/bms_selector.sv
// start-up mode selector: stored config, download or test mode
`timescale 1ns/1ps
`default_nettype none
`include "bms_params.svh"
module bms_selector
(
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic otp_ready,
    input wire logic otp_valid,
    input wire logic rx_valid,
    input wire logic [7:0] rx_data,
    input wire logic [`BMS_CFG_ADDR_W-1:0] cfg_rd_addr,
    output logic [7:0] cfg_rd_data,
    output logic uart_enable,
    output logic use_otp_cfg,
    output logic cfg_loaded,
    output logic pm_enable,
    output logic mode_normal,
    output logic mode_download,
    output logic mode_test,
    output logic dl_valid,
    output logic [7:0] dl_data,
    output logic dtm_valid,
    output logic [7:0] dtm_data
);
    typedef struct packed {
        bms_pkg::bms_mode_t mode;
        logic [`BMS_CFG_ADDR_W-1:0] wptr;
        logic loaded;
        logic uart_en;
        logic pm_en;
        logic dl_v;
        logic [7:0] dl_d;
        logic dtm_v;
        logic [7:0] dtm_d;
        logic m_norm;
        logic m_dl;
        logic m_test;
    } bms_state_t;

    bms_state_t st;
    bms_state_t next_st;
    logic ram_we;

    ////////////////////////////////////////////////////////////////////////
    // mode decision
    function automatic bms_pkg::bms_mode_t pick_mode(input logic [7:0] b);
        if (b == `BMS_DL_SELECT_BYTE)
        begin
            pick_mode = bms_pkg::BMS_DOWNLOAD;
        end
        else
        begin
            pick_mode = bms_pkg::BMS_TEST;
        end
    endfunction

    always_comb
    begin
        next_st = st;
        next_st.dl_v = 1'b0;
        next_st.dtm_v = 1'b0;
        ram_we = 1'b0;
        case (st.mode)
            bms_pkg::BMS_CHECK:
            begin
                if (otp_ready && otp_valid)
                begin
                    next_st.mode = bms_pkg::BMS_NORMAL_OTP;
                    next_st.uart_en = 1'b0;
                    next_st.pm_en = 1'b1;
                end
                else if (otp_ready)
                begin
                    next_st.mode = bms_pkg::BMS_WAIT_BYTE;
                    next_st.uart_en = 1'b1;
                end
            end
            bms_pkg::BMS_WAIT_BYTE:
            begin
                if (rx_valid)
                begin
                    next_st.mode = pick_mode(rx_data);
                    next_st.pm_en = 1'b0;
                end
            end
            bms_pkg::BMS_DOWNLOAD:
            begin
                if (rx_valid)
                begin
                    ram_we = 1'b1;
                    next_st.wptr = st.wptr + 1'b1;
                    next_st.loaded = 1'b1;
                    next_st.dl_v = 1'b1;
                    next_st.dl_d = rx_data;
                end
            end
            bms_pkg::BMS_TEST:
            begin
                if (rx_valid)
                begin
                    next_st.dtm_v = 1'b1;
                    next_st.dtm_d = rx_data;
                end
            end
            bms_pkg::BMS_NORMAL_OTP:
            begin
                next_st.uart_en = 1'b0;
            end
            default:
            begin
                next_st.mode = bms_pkg::BMS_CHECK;
            end
        endcase
        // mode flags registered so the outputs come from flip-flops
        next_st.m_norm = (next_st.mode == bms_pkg::BMS_NORMAL_OTP);
        next_st.m_dl = (next_st.mode == bms_pkg::BMS_DOWNLOAD);
        next_st.m_test = (next_st.mode == bms_pkg::BMS_TEST);
    end

    // reset clears mode and ram-config flag, forcing a fresh decision
    always_ff @(posedge ref_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            st <= '0;
        end
        else
        begin
            st <= next_st;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // config store
    bms_cfg_ram bms_cfg_ram_i
    (
        .ref_clk(ref_clk),
        .wr_en(ram_we),
        .wr_addr(st.wptr),
        .wr_data(rx_data),
        .rd_addr(cfg_rd_addr),
        .rd_data(cfg_rd_data)
    );

    ////////////////////////////////////////////////////////////////////////
    // outputs
    always_comb
    begin
        uart_enable = st.uart_en;
        use_otp_cfg = st.m_norm;
        cfg_loaded = st.loaded;
        pm_enable = st.pm_en;
        mode_normal = st.m_norm;
        mode_download = st.m_dl;
        mode_test = st.m_test;
        dl_valid = st.dl_v;
        dl_data = st.dl_d;
        dtm_valid = st.dtm_v;
        dtm_data = st.dtm_d;
    end

    ////////////////////////////////////////////////////////////////////////
    // checks
    sequence s_otp_found;
        st.mode == bms_pkg::BMS_CHECK && otp_ready && otp_valid;
    endsequence

    sequence s_first_byte(logic [7:0] b);
        st.mode == bms_pkg::BMS_WAIT_BYTE && rx_valid && rx_data == b;
    endsequence

    property p_restart;
        @(posedge ref_clk) $fell(sys_rst) |-> st.mode == bms_pkg::BMS_CHECK
            && !st.loaded;
    endproperty
    a_restart: assert property (p_restart) else $error("no restart");

    property p_otp_start;
        @(posedge ref_clk) disable iff (sys_rst)
            s_otp_found |=> mode_normal;
    endproperty
    a_otp_start: assert property (p_otp_start) else $error("otp start");

    property p_dl_sel;
        @(posedge ref_clk) disable iff (sys_rst)
            s_first_byte(8'hFF) |=> mode_download && !pm_enable;
    endproperty
    a_dl_sel: assert property (p_dl_sel) else $error("download sel");

    property p_test_sel;
        @(posedge ref_clk) disable iff (sys_rst)
            st.mode == bms_pkg::BMS_WAIT_BYTE && rx_valid
            && rx_data != 8'hFF |=> mode_test;
    endproperty
    a_test_sel: assert property (p_test_sel) else $error("test sel");

    property p_store;
        @(posedge ref_clk) disable iff (sys_rst)
            mode_download && rx_valid |=> dl_valid && cfg_loaded
            && st.wptr == $past(st.wptr) + 1'b1;
    endproperty
    a_store: assert property (p_store) else $error("store");

    property p_volatile;
        @(posedge ref_clk) disable iff (sys_rst)
            cfg_loaded |-> mode_download;
    endproperty
    a_volatile: assert property (p_volatile) else $error("volatile");

    property p_no_pm;
        @(posedge ref_clk) disable iff (sys_rst)
            (mode_test || mode_download) |-> !pm_enable;
    endproperty
    a_no_pm: assert property (p_no_pm) else $error("pm on");

    property p_no_test;
        @(posedge ref_clk) disable iff (sys_rst)
            mode_normal |=> !mode_test && mode_normal;
    endproperty
    a_no_test: assert property (p_no_test) else $error("test reached");

    property p_uart_off;
        @(posedge ref_clk) disable iff (sys_rst)
            mode_normal |-> !uart_enable;
    endproperty
    a_uart_off: assert property (p_uart_off) else $error("uart on");

    property p_route;
        @(posedge ref_clk) disable iff (sys_rst)
            mode_test && rx_valid |=> dtm_valid && dtm_data == $past(rx_data)
            && !dl_valid;
    endproperty
    a_route: assert property (p_route) else $error("route");
endmodule
`default_nettype wire

// >>> include/bms_params.svh
// constants for the start-up mode selector
`ifndef BMS_PARAMS_SVH
`define BMS_PARAMS_SVH
`define BMS_DL_SELECT_BYTE 8'hFF
`define BMS_CFG_WORDS 64
`define BMS_CFG_ADDR_W 6
`define BMS_CFG_RST 8'h00
`endif

// >>> include/bms_pkg.sv
// types for the start-up mode selector
package bms_pkg;
    typedef enum logic [2:0] {
        BMS_CHECK,
        BMS_WAIT_BYTE,
        BMS_NORMAL_OTP,
        BMS_DOWNLOAD,
        BMS_TEST
    } bms_mode_t;
endpackage

// >>> rtl/bms_cfg_ram.sv
// volatile configuration store for download mode
`timescale 1ns/1ps
`default_nettype none
`include "bms_params.svh"
module bms_cfg_ram
(
    input wire logic ref_clk,
    input wire logic wr_en,
    input wire logic [`BMS_CFG_ADDR_W-1:0] wr_addr,
    input wire logic [7:0] wr_data,
    input wire logic [`BMS_CFG_ADDR_W-1:0] rd_addr,
    output logic [7:0] rd_data
);
    logic [7:0] mem [0:`BMS_CFG_WORDS-1];

    // held only while powered; contents are never trusted across reset
    always_ff @(posedge ref_clk)
    begin
        if (wr_en)
        begin
            mem[wr_addr] <= wr_data;
        end
        rd_data <= mem[rd_addr];
    end
endmodule
`default_nettype wire

// >>> verification/bms_host_model.sv
// host tool model: sends uart bytes
`timescale 1ns/1ps
`default_nettype none
module bms_host_model
(
    input wire logic ref_clk,
    output logic rx_valid,
    output logic [7:0] rx_data
);
    initial
    begin
        rx_valid = 1'b0;
        rx_data = 8'h00;
    end
    ////////////////////////////////////////
    // one-cycle byte, data inverted once released
    task automatic send(input logic [7:0] b);
    begin
        @(posedge ref_clk);
        rx_valid <= 1'b1;
        rx_data <= b;
        @(posedge ref_clk);
        rx_valid <= 1'b0;
        rx_data <= ~b;
    end
    endtask
endmodule
`default_nettype wire

// >>> verification/bms_selector_test.sv
// bench for the start-up mode selector
`timescale 1ns/1ps
`default_nettype none
`include "bms_params.svh"
module bms_selector_test;
    logic ref_clk, sys_rst, otp_ready, otp_valid, rx_valid;
    logic [7:0] rx_data, cfg_rd_data, dl_data, dtm_data;
    logic [`BMS_CFG_ADDR_W-1:0] cfg_rd_addr;
    logic uart_enable, use_otp_cfg, cfg_loaded, pm_enable;
    logic mode_normal, mode_download, mode_test, dl_valid, dtm_valid;
    int fail_count, check_count, cycles;
    localparam logic [7:0] SEL = `BMS_DL_SELECT_BYTE;
    bms_selector bms_selector_i
    (
        .ref_clk, .sys_rst, .otp_ready, .otp_valid, .rx_valid, .rx_data,
        .cfg_rd_addr, .cfg_rd_data, .uart_enable, .use_otp_cfg,
        .cfg_loaded, .pm_enable, .mode_normal, .mode_download,
        .mode_test, .dl_valid, .dl_data, .dtm_valid, .dtm_data
    );
    bms_host_model bms_host_model_i
    (
        .ref_clk, .rx_valid, .rx_data
    );
    initial
    begin
        ref_clk = 1'b0;
        forever #50 ref_clk = ~ref_clk;
    end
    ////////////////////////////////////////
    task automatic final_report;
    begin
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    end
    endtask
    always @(posedge ref_clk)
    begin
        cycles++;
        if (cycles == 32'h0000_0BB8)
        begin
            fail_count++;
            final_report();
        end
    end
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    begin
        check_count++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("[FAIL] %0t saw %h expected %h", $time, seen, exp);
        end
    end
    endtask
    // reset, then let the stored-config status be taken
    task automatic start(input logic v);
    begin
        @(posedge ref_clk);
        sys_rst <= 1'b1;
        otp_ready <= 1'b0;
        otp_valid <= v;
        repeat (6) @(posedge ref_clk);
        sys_rst <= 1'b0;
        @(posedge ref_clk);
        otp_ready <= 1'b1;
        @(posedge ref_clk);
        #1;
    end
    endtask
    task automatic tx(input logic [7:0] b);
    begin
        bms_host_model_i.send(b);
        #1;
    end
    endtask
    ////////////////////////////////////////
    task automatic test_otp;
    begin
        start(1'b1);
        check({7'h00, mode_normal}, 8'h01);
        check({7'h00, uart_enable}, 8'h00);
        tx(8'h12);
        check({7'h00, mode_test}, 8'h00);
        check({7'h00, dtm_valid}, 8'h00);
        tx(SEL);
        check({7'h00, mode_download}, 8'h00);
        check({7'h00, pm_enable}, 8'h01);
        check({7'h00, use_otp_cfg}, 8'h01);
        $display("test otp done");
    end
    endtask
    task automatic test_download;
    begin
        start(1'b0);
        check({7'h00, uart_enable}, 8'h01);
        check({7'h00, mode_download}, 8'h00);
        tx(SEL);
        check({7'h00, mode_download}, 8'h01);
        check({7'h00, dl_valid}, 8'h00);
        check({7'h00, pm_enable}, 8'h00);
        tx(8'hA5);
        check({7'h00, dl_valid}, 8'h01);
        check(dl_data, 8'hA5);
        check({7'h00, cfg_loaded}, 8'h01);
        tx(SEL);
        check(dl_data, SEL);
        check({7'h00, mode_test}, 8'h00);
        @(posedge ref_clk);
        cfg_rd_addr <= '0;
        @(posedge ref_clk);
        cfg_rd_addr <= 6'h01;
        #1;
        check(cfg_rd_data, 8'hA5);
        @(posedge ref_clk);
        #1;
        check(cfg_rd_data, SEL);
        $display("test download done");
    end
    endtask
    task automatic test_dtm;
    begin
        start(1'b0);
        check({7'h00, cfg_loaded}, 8'h00);
        check({7'h00, mode_download}, 8'h00);
        check({7'h00, uart_enable}, 8'h01);
        tx(8'hFE);
        check({7'h00, mode_test}, 8'h01);
        check({7'h00, dtm_valid}, 8'h00);
        check({7'h00, pm_enable}, 8'h00);
        tx(SEL);
        check({7'h00, dtm_valid}, 8'h01);
        check(dtm_data, SEL);
        check({7'h00, mode_download}, 8'h00);
        $display("test dtm done");
    end
    endtask
    initial
    begin
        sys_rst = 1'b1;
        otp_ready = 1'b0;
        otp_valid = 1'b0;
        cfg_rd_addr = '0;
        fail_count = 0;
        check_count = 0;
        cycles = 0;
        test_otp();
        test_download();
        test_dtm();
        final_report();
    end
endmodule
`default_nettype wire
